// [core/select_vector_defines.svh]
`ifndef SELECT_VECTOR_DEFINES_SVH
`define SELECT_VECTOR_DEFINES_SVH

// Register map (word index on the host port)
`define SEL_REG_SELECT 1'h0
`define SEL_REG_DIAG 1'h1
// Field positions of the select register
`define SEL_CODE_HI 15
`define SEL_CODE_LO 12
`define SEL_RSVD_HI 11
`define SEL_RSVD_LO 8
`define SEL_VEC_HI 7
`define SEL_VEC_LO 0
// Availability codes
`define SEL_CODE_ASYNC 4'h8
`define SEL_CODE_ASYNC_PRN 4'hA
`define SEL_CODE_ASYNC_SYNC_PAR 4'hD
`define SEL_CODE_ASYNC_SYNC_PRN 4'hE
// Reset values
`define SEL_VEC_RESET 8'h00
`define DIAG_RESET 16'h0000
// Vector spacing and count
`define SEL_VEC_STEP 8'h04
`define SEL_VEC_COUNT 8

`endif

// [core/select_vector_pkg.sv]
package select_vector_pkg;
  // Derived vector slots in ascending order
  typedef enum logic [2:0] {
    VEC_SYNC_RX = 3'h0,
    VEC_SYNC_TX = 3'h1,
    VEC_PAR_A = 3'h2,
    VEC_PAR_B = 3'h3,
    VEC_ASYNC_RX = 3'h4,
    VEC_ASYNC_TX = 3'h5,
    VEC_PRINTER = 3'h6,
    VEC_UNUSED = 3'h7
  } vec_slot_t;

  // Power-up sampling sequence
  typedef enum logic [2:0] {
    ST_SYNC = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN = 3'b100
  } boot_state_t;
endpackage : select_vector_pkg

// [core/shared_select_vector_register.sv]
// How it works
// R1 - Only two shared registers exist, the select register and the diagnostic register.
// R2 - The select register holds a 4-bit code saying which sub-devices are available.
// R3 - Parallel port and printer controller are never enabled together.
// R4 - The two selection switches are sampled once after reset and then ignored.
// R5 - After reset a program write to bits 15:12 can change the availability code.
// R6 - A full word write updates both the code and the base vector.
// R7 - Any byte write loads only the vector byte, whichever byte address is used.
// R8 - Software must write the base vector since no switches supply it.
// R9 - Seven more vectors follow the base in a contiguous ascending series.
// R10 - Valid codes are 1000, 1010, 1101 and 1110 with their device sets.
// R11 - Bits 11:8 ignore writes and read as zero.
// R12 - Vectors are spaced four apart in the fixed device order.
// R13 - At reset the code follows the switches; invalid written codes are undefined.
`timescale 1ns/100ps
`include "select_vector_defines.svh"
module shared_select_vector_register
  import select_vector_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Selection switches (asynchronous pins)
  input wire logic [1:0] select_switch_i,
  // Host register port
  input wire logic reg_sel_i,
  input wire logic reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_byte_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  // Sub-device availability
  output logic async_en_o,
  output logic sync_en_o,
  output logic parallel_port_function_en_o,
  output logic printer_controller_function_en_o,
  // Derived vectors, slot i in bits 8i+7:8i
  output logic [63:0] vectors_o
);

  // Switch synchroniser; the pins may move at any time relative to clk_i
  logic [1:0] sw_meta_r, sw_meta_nxt;
  logic [1:0] sw_sync_r, sw_sync_nxt;
  // Boot and register state
  boot_state_t boot_r, boot_nxt;
  logic [3:0] code_r, code_nxt;
  logic [7:0] vec_r, vec_nxt;
  // Diagnostic store: plain word read and write, no side effects here
  logic [15:0] diag_r, diag_nxt;
  // Output registers
  logic [15:0] rdata_r, rdata_nxt;
  logic async_r, async_nxt;
  logic sync_r, sync_nxt;
  logic par_r, par_nxt;
  logic prn_r, prn_nxt;
  logic [63:0] vecs_r;

  vector_if vif ();

  vector_gen u_gen (
    .vif(vif)
  );

  // Map the switch pair onto the four valid codes
  function automatic logic [3:0] switch_code(input logic [1:0] sw);
    case (sw)
      2'h0: switch_code = `SEL_CODE_ASYNC;
      2'h1: switch_code = `SEL_CODE_ASYNC_PRN;
      2'h2: switch_code = `SEL_CODE_ASYNC_SYNC_PAR;
      default: switch_code = `SEL_CODE_ASYNC_SYNC_PRN;
    endcase
  endfunction : switch_code

  // Pick the data lane of a byte write: high lane for the odd byte address
  function automatic logic [7:0] byte_lane(input logic addr, input logic [15:0] data);
    if (addr) begin
      byte_lane = data[15:8];
    end else begin
      byte_lane = data[7:0];
    end
  endfunction : byte_lane

  // Synchroniser next values; first stage feeds only the second
  always_comb begin
    sw_meta_nxt = select_switch_i;
    sw_sync_nxt = sw_meta_r;
  end

  // No reset here: the pair keeps sampling through reset, so the switch
  // value has settled by the time the boot sequence loads the code
  always_ff @(posedge clk_i) begin
    sw_meta_r <= sw_meta_nxt;
    sw_sync_r <= sw_sync_nxt;
  end

  // Register file next values; sample switches once, then host writes
  always_comb begin
    boot_nxt = boot_r;
    code_nxt = code_r;
    vec_nxt = vec_r;
    diag_nxt = diag_r;
    case (boot_r)
      ST_SYNC: begin
        // Wait for the synchroniser to fill before trusting it
        boot_nxt = ST_LOAD;
      end
      ST_LOAD: begin
        // Taken exactly once; later switch moves wait for the next reset
        code_nxt = switch_code(sw_sync_r); // R4 R13
        boot_nxt = ST_RUN;
      end
      ST_RUN: begin
        // Switches are no longer looked at here
        if (reg_sel_i && reg_wr_i) begin
          if (reg_byte_i) begin
            // A byte write always means the select register; the byte
            // address only picks the lane, and the code is left alone
            vec_nxt = byte_lane(reg_addr_i, reg_wdata_i); // R7
          end else if (reg_addr_i == `SEL_REG_SELECT) begin
            code_nxt = reg_wdata_i[`SEL_CODE_HI:`SEL_CODE_LO]; // R5 R6
            vec_nxt = reg_wdata_i[`SEL_VEC_HI:`SEL_VEC_LO]; // R6
          end else begin
            // Diagnostic store is word-only
            diag_nxt = reg_wdata_i; // R1
          end
        end
      end
      default: begin
        boot_nxt = ST_SYNC;
      end
    endcase
  end

  // Every reset restarts the boot sequence and so samples the switches again
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      boot_r <= ST_SYNC;
      code_r <= `SEL_CODE_ASYNC;
      vec_r <= `SEL_VEC_RESET;
      diag_r <= `DIAG_RESET;
    end else begin
      boot_r <= boot_nxt;
      code_r <= code_nxt;
      vec_r <= vec_nxt;
      diag_r <= diag_nxt;
    end
  end

  // Byte-wide reads are served as a full word; the host picks its lane
  always_comb begin
    rdata_nxt = 16'h0000;
    if (reg_addr_i == `SEL_REG_SELECT) begin
      // Reserved bits are not stored at all, so they can only read as zero
      rdata_nxt = {code_r, 4'h0, vec_r}; // R1 R2 R11
    end else begin
      rdata_nxt = diag_r; // R1
    end
  end

  // Decode availability; unknown codes enable only the async lines
  always_comb begin
    async_nxt = 1'b1;
    sync_nxt = 1'b0;
    par_nxt = 1'b0;
    prn_nxt = 1'b0;
    case (code_r) // R10
      `SEL_CODE_ASYNC: begin
        async_nxt = 1'b1;
      end
      `SEL_CODE_ASYNC_PRN: begin
        prn_nxt = 1'b1;
      end
      `SEL_CODE_ASYNC_SYNC_PAR: begin
        sync_nxt = 1'b1;
        par_nxt = 1'b1;
      end
      `SEL_CODE_ASYNC_SYNC_PRN: begin
        sync_nxt = 1'b1;
        prn_nxt = 1'b1;
      end
      default: begin
        // Invalid code: keep the risky pair off rather than guess
        async_nxt = 1'b1; // R13
      end
    endcase
    // Never both at once, even if the decode above were widened
    if (par_nxt) begin
      prn_nxt = 1'b0; // R3
    end
  end

  // Vector base from the stored byte; software must load it
  // No carry leaves bit 7, so the derived series wraps inside the byte
  assign vif.base = vec_r; // R8

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_r <= 16'h0000;
      async_r <= 1'b0;
      sync_r <= 1'b0;
      par_r <= 1'b0;
      prn_r <= 1'b0;
      vecs_r <= 64'h0;
    end else begin
      rdata_r <= rdata_nxt;
      async_r <= async_nxt;
      sync_r <= sync_nxt;
      par_r <= par_nxt;
      prn_r <= prn_nxt;
      vecs_r <= vif.vectors; // R9
    end
  end

  // Ports come straight from the output flops
  assign reg_rdata_o = rdata_r;
  assign async_en_o = async_r;
  assign sync_en_o = sync_r;
  assign parallel_port_function_en_o = par_r;
  assign printer_controller_function_en_o = prn_r;
  assign vectors_o = vecs_r;

endmodule : shared_select_vector_register

// [core/vector_gen.sv]
`timescale 1ns/100ps
`include "select_vector_defines.svh"
module vector_gen
  import select_vector_pkg::*;
(
  vector_if.gen vif
);

  // Base plus slot times step; wraps modulo 256 like the vector byte
  function automatic logic [7:0] slot_vec(input logic [7:0] base, input logic [2:0] slot);
    slot_vec = base + 8'({5'h00, slot} * `SEL_VEC_STEP);
  endfunction : slot_vec

  // Contiguous ascending series above the base
  always_comb begin
    for (int i = 0; i < `SEL_VEC_COUNT; i++) begin
      vif.vectors[i*8 +: 8] = slot_vec(vif.base, 3'(i)); // R9 R12
    end
  end
endmodule : vector_gen

// [core/vector_if.sv]
`timescale 1ns/100ps
// Carries the base vector into the generator and the eight vectors back
interface vector_if;
  logic [7:0] base;
  logic [63:0] vectors;
  modport gen (input base, output vectors);
  modport user (output base, input vectors);
endinterface : vector_if

// [verif/host_model.sv]
`timescale 1ns/100ps
module host_model (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic sel_o,
  output logic addr_o,
  output logic wr_o,
  output logic byte_o,
  output logic [15:0] wdata_o,
  input wire logic [15:0] rdata_i
);
  initial {sel_o, addr_o, wr_o, byte_o, wdata_o} = 20'h00000;
  // One access per call; data inverted on release so it never looks valid
  task access(input logic w, input logic b, input logic a, input logic [15:0] d,
    output logic [15:0] q);
    @(negedge clk_i);
    {sel_o, wr_o, byte_o, addr_o, wdata_o} = {1'b1, w, b, a, d};
    @(negedge clk_i);
    q = rdata_i;
    {sel_o, wdata_o} = {1'b0, ~d};
  endtask : access
endmodule : host_model

// [verif/select_vector_assertions.sv]
`timescale 1ns/100ps
module select_vector_assertions (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Host port
  input wire logic reg_sel_i,
  input wire logic reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_byte_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  // Outputs
  input wire logic async_en_o,
  input wire logic sync_en_o,
  input wire logic parallel_port_function_en_o,
  input wire logic printer_controller_function_en_o,
  input wire logic [63:0] vectors_o
);
  // Boot takes three edges and drops writes, so nothing is judged before
  logic [1:0] up_r;
  logic [1:0] up_nxt;
  logic run;
  logic wr;
  logic [3:0] en;
  always_comb up_nxt = (up_r == 2'h3) ? up_r : up_r + 2'h1;
  always_ff @(posedge clk_i) up_r <= reset_i ? 2'h0 : up_nxt;
  assign run = (up_r == 2'h3);
  assign wr = run && reg_sel_i && reg_wr_i;
  assign en = {async_en_o, sync_en_o, parallel_port_function_en_o,
    printer_controller_function_en_o};
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_excl; run |-> !(en[1] && en[0]); endproperty
  a_excl: assert property (p_excl) else $error("both port functions on");
  property p_async; run |-> en[3]; endproperty
  a_async: assert property (p_async) else $error("async off");
  property p_step; run |-> vectors_o[15:8] == vectors_o[7:0] + 8'h04; endproperty
  a_step: assert property (p_step) else $error("vector step");
  property p_top; run |-> vectors_o[63:56] == vectors_o[7:0] + 8'h1C; endproperty
  a_top: assert property (p_top) else $error("last vector");
  property p_word; wr && !reg_byte_i && !reg_addr_i ##1 !reg_addr_i
    |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 16'hF0FF); endproperty
  a_word: assert property (p_word) else $error("word write");
  property p_blo; wr && reg_byte_i && !reg_addr_i
    |-> ##2 vectors_o[7:0] == 8'($past(reg_wdata_i, 2)); endproperty
  a_blo: assert property (p_blo) else $error("low byte");
  property p_bhi; wr && reg_byte_i && reg_addr_i
    |-> ##2 vectors_o[7:0] == 8'($past(reg_wdata_i, 2) >> 8); endproperty
  a_bhi: assert property (p_bhi) else $error("high byte");
  property p_keep; wr && reg_byte_i ##1 !(reg_sel_i && reg_wr_i) |=> $stable(en); endproperty
  a_keep: assert property (p_keep) else $error("code moved");
endmodule : select_vector_assertions
bind shared_select_vector_register select_vector_assertions i_chk (.clk_i, .reset_i,
  .reg_sel_i, .reg_addr_i, .reg_wr_i, .reg_byte_i, .reg_wdata_i, .reg_rdata_o, .async_en_o,
  .sync_en_o, .parallel_port_function_en_o, .printer_controller_function_en_o, .vectors_o);

// [verif/testbench.sv]
`timescale 1ns/100ps
module testbench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [1:0] sw = 2'h1;
  logic sel, addr, wr, byt;
  logic [15:0] wd, rd, q;
  logic [3:0] en;
  logic [63:0] vec;
  logic [3:0] codes[4] = '{4'h8, 4'hA, 4'hD, 4'hE};
  logic [3:0] ens[4] = '{4'h8, 4'h9, 4'hE, 4'hD};
  int mismatches = 0;
  int checks = 0;
  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;
  shared_select_vector_register i_dut (.clk_i, .reset_i, .select_switch_i(sw),
    .reg_sel_i(sel), .reg_addr_i(addr), .reg_wr_i(wr), .reg_byte_i(byt), .reg_wdata_i(wd),
    .reg_rdata_o(rd), .async_en_o(en[3]), .sync_en_o(en[2]),
    .parallel_port_function_en_o(en[1]), .printer_controller_function_en_o(en[0]),
    .vectors_o(vec));
  host_model i_host (.clk_i, .sel_o(sel), .addr_o(addr), .wr_o(wr), .byte_o(byt),
    .wdata_o(wd), .rdata_i(rd));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Read after an idle edge, so a preceding write has landed
  task rd_chk(input logic a, input logic [15:0] exp);
    i_host.access(1'b0, 1'b0, a, 16'h0000, q);
    chk(q, exp);
  endtask : rd_chk
  task chk_vec(input logic [7:0] b);
    for (int i = 0; i < 8; i++) chk({8'h00, vec[8*i+:8]}, {8'h00, b + 8'(4 * i)});
  endtask : chk_vec
  task t_boot;
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (6) @(negedge clk_i);
    sw = 2'h3;
    repeat (4) @(negedge clk_i);
    rd_chk(1'b0, 16'hA000);
    chk({12'h000, en}, 16'h0009);
  endtask : t_boot
  task t_codes;
    // An invalid code must leave only the async lines on
    i_host.access(1'b1, 1'b0, 1'b0, 16'h3F40, q);
    rd_chk(1'b0, 16'h3040);
    chk({12'h000, en}, 16'h0008);
    for (int i = 0; i < 4; i++) begin
      i_host.access(1'b1, 1'b0, 1'b0, {codes[i], 4'hF, 8'h40 + 8'(i)}, q);
      rd_chk(1'b0, {codes[i], 4'h0, 8'h40 + 8'(i)});
      chk({12'h000, en}, {12'h000, ens[i]});
      chk_vec(8'h40 + 8'(i));
    end
  endtask : t_codes
  task t_byte;
    i_host.access(1'b1, 1'b1, 1'b0, 16'h5533, q);
    rd_chk(1'b0, 16'hE033);
    i_host.access(1'b1, 1'b1, 1'b1, 16'hFC11, q);
    rd_chk(1'b0, 16'hE0FC);
    chk({12'h000, en}, 16'h000D);
    chk_vec(8'hFC);
  endtask : t_byte
  task t_diag;
    i_host.access(1'b1, 1'b0, 1'b1, 16'h1234, q);
    rd_chk(1'b1, 16'h1234);
    rd_chk(1'b0, 16'hE0FC);
  endtask : t_diag
  task conclude;
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  initial begin
    t_boot();
    t_codes();
    t_byte();
    t_diag();
    conclude();
  end
  // Run needs about 50 cycles; 2000 means a hang
  initial begin
    #10000;
    mismatches++;
    conclude();
  end
endmodule : testbench
